/* rtl/aoms_axis_flags.sv */
`timescale 1ns/100ps
module aoms_axis_flags (
  input  wire logic   clk_in,      // Core clock
  input  wire logic   reset_n_in,  // Synchronous reset, active low
  aoms_axis_if.flags  axis         // Per-axis event and flag bundle
);

  logic ready;
  logic ovw;
  logic next_ready;
  logic next_ovw;

  // Set wins over clear so an acquisition landing on the read is kept
  always_comb begin
    next_ready = axis.acq | (ready & ~axis.msb_rd);
    next_ovw   = (axis.acq & ready) | (ovw & ~axis.msb_rd);
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      ready <= 1'b0;
      ovw   <= 1'b0;
    end else begin
      ready <= next_ready;
      ovw   <= next_ovw;
    end
  end

  assign axis.ready = ready;
  assign axis.ovw   = ovw;

endmodule : aoms_axis_flags

/* rtl/aoms_axis_if.sv */
`timescale 1ns/100ps
interface aoms_axis_if;
  logic acq;     // New acquisition for this axis completed
  logic msb_rd;  // Host read of this axis high byte
  logic ready;   // Axis new data flag
  logic ovw;     // Axis overwrite flag

  modport flags (input acq, input msb_rd, output ready, output ovw);
  modport ctrl  (output acq, output msb_rd, input ready, input ovw);
endinterface : aoms_axis_if

/* rtl/aoms_pkg.sv */
package aoms_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ACCEL_X_OFFSET_ADDR    = 8'h2F;
  localparam logic [7:0] ACCEL_Y_OFFSET_ADDR    = 8'h30;
  localparam logic [7:0] ACCEL_Z_OFFSET_ADDR    = 8'h31;
  localparam logic [7:0] MAG_SAMPLE_STATUS_ADDR = 8'h32;
  localparam logic [7:0] MAG_X_HIGH_ADDR        = 8'h33;
  localparam logic [7:0] MAG_Y_HIGH_ADDR        = 8'h35;
  localparam logic [7:0] MAG_Z_HIGH_ADDR        = 8'h37;

  localparam logic [7:0] OFFSET_RESET           = 8'h00;
  localparam logic [7:0] STATUS_RESET           = 8'h00;
  localparam logic [7:0] UNMAPPED_READ          = 8'h00;

  // ----------------------------------------------------------------
  // Status field positions
  // ----------------------------------------------------------------
  localparam int STAT_XDR   = 0;
  localparam int STAT_YDR   = 1;
  localparam int STAT_ZDR   = 2;
  localparam int STAT_XYZDR = 3;
  localparam int STAT_XOW   = 4;
  localparam int STAT_YOW   = 5;
  localparam int STAT_ZOW   = 6;
  localparam int STAT_XYZOW = 7;

  // ----------------------------------------------------------------
  // Acceleration data path
  // ----------------------------------------------------------------
  localparam int ACCEL_W      = 14;
  localparam int SUM_W        = 16;
  // 2 mg per offset step against 0.25 mg per output step
  localparam int OFFSET_SHIFT = 3;
  localparam logic signed [SUM_W-1:0] ACCEL_MAX = 16'sh1FFF;
  localparam logic signed [SUM_W-1:0] ACCEL_MIN = -16'sh2000;

endpackage : aoms_pkg

/* rtl/aoms_regs.sv */
`timescale 1ns/100ps
// How it works
// - Offset registers change only in standby; host must enter standby first.
// - X offset: 8-bit signed, address 0x2F, read/write, resets to zero.
// - Y offset: 8-bit signed, address 0x30, read/write, resets to zero.
// - Z offset: 8-bit signed, address 0x31, read/write, resets to zero.
// - Status at 0x32, read-only, zero at reset, overwrite bits high, ready low.
// - Whole-set overwrite sets when new data arrives before previous set fully read.
// - Whole-set overwrite clears once all three axis high bytes are read, unless any axis acquisition completes in that cycle.
// - Z overwrite sets when Z acquisition completes before previous Z was read.
// - Z overwrite clears when the Z high byte is read, unless a Z acquisition completes in that cycle.
// - Y overwrite sets when Y acquisition completes before previous Y was read.
// - Y overwrite clears when the Y high byte is read, unless a Y acquisition completes in that cycle.
// - X overwrite sets when X acquisition completes before previous X was read.
// - X overwrite clears when the X high byte is read, unless an X acquisition completes in that cycle.
// - Offsets, 2 mg per step, are added to raw acceleration before output.
// - Axis ready sets on its acquisition, clears on its high byte read.
// - Whole-set ready marks a fresh XYZ set, clears after all high bytes read.
module aoms_regs (
  input  wire logic        clk_in,            // Core clock, 250 MHz
  input  wire logic        reset_n_in,        // Synchronous reset, active low
  input  wire logic [7:0]  reg_addr_in,       // Register address
  input  wire logic        reg_wr_in,         // Write strobe, one cycle
  input  wire logic        reg_rd_in,         // Read strobe, one cycle
  input  wire logic [7:0]  reg_wdata_in,      // Write data
  output logic      [7:0]  reg_rdata_out,     // Read data, cycle after strobe
  input  wire logic        standby_in,        // Device in standby
  input  wire logic        mag_acq_x_in,      // X magnetic acquisition done
  input  wire logic        mag_acq_y_in,      // Y magnetic acquisition done
  input  wire logic        mag_acq_z_in,      // Z magnetic acquisition done
  input  wire logic        accel_valid_in,    // Raw acceleration sample valid
  input  wire logic [13:0] accel_raw_x_in,    // Raw X acceleration
  input  wire logic [13:0] accel_raw_y_in,    // Raw Y acceleration
  input  wire logic [13:0] accel_raw_z_in,    // Raw Z acceleration
  output logic             accel_valid_out,   // Corrected sample valid
  output logic      [13:0] accel_x_out,       // Corrected X acceleration
  output logic      [13:0] accel_y_out,       // Corrected Y acceleration
  output logic      [13:0] accel_z_out,       // Corrected Z acceleration
  output logic      [7:0]  mag_status_out     // Live status byte
);

  // ----------------------------------------------------------------
  // Per-axis flags
  // ----------------------------------------------------------------
  aoms_axis_if ax_x ();
  aoms_axis_if ax_y ();
  aoms_axis_if ax_z ();

  logic rd_x_high;
  logic rd_y_high;
  logic rd_z_high;
  logic any_acq;

  assign rd_x_high = reg_rd_in && (reg_addr_in == aoms_pkg::MAG_X_HIGH_ADDR);
  assign rd_y_high = reg_rd_in && (reg_addr_in == aoms_pkg::MAG_Y_HIGH_ADDR);
  assign rd_z_high = reg_rd_in && (reg_addr_in == aoms_pkg::MAG_Z_HIGH_ADDR);
  assign any_acq   = mag_acq_x_in | mag_acq_y_in | mag_acq_z_in;

  assign ax_x.acq    = mag_acq_x_in;
  assign ax_x.msb_rd = rd_x_high;
  assign ax_y.acq    = mag_acq_y_in;
  assign ax_y.msb_rd = rd_y_high;
  assign ax_z.acq    = mag_acq_z_in;
  assign ax_z.msb_rd = rd_z_high;

  aoms_axis_flags u_flags_x (.clk_in(clk_in), .reset_n_in(reset_n_in), .axis(ax_x));
  aoms_axis_flags u_flags_y (.clk_in(clk_in), .reset_n_in(reset_n_in), .axis(ax_y));
  aoms_axis_flags u_flags_z (.clk_in(clk_in), .reset_n_in(reset_n_in), .axis(ax_z));

  // ----------------------------------------------------------------
  // Whole-set flags
  // ----------------------------------------------------------------
  logic       set_ready;
  logic       set_ovw;
  logic [2:0] high_seen;
  logic       next_set_ready;
  logic       next_set_ovw;
  logic [2:0] next_high_seen;
  logic [2:0] seen_now;
  logic       set_done;
  logic       set_fresh;

  // A set is fresh once every axis holds unread data after an acquisition
  // The seen mask restarts with each fresh set, so reads of an older set never count
  always_comb begin
    seen_now       = high_seen | {rd_z_high, rd_y_high, rd_x_high};
    set_done       = &seen_now;
    set_fresh      = any_acq && (mag_acq_x_in | (ax_x.ready & ~rd_x_high))
                             && (mag_acq_y_in | (ax_y.ready & ~rd_y_high))
                             && (mag_acq_z_in | (ax_z.ready & ~rd_z_high));
    next_high_seen = (set_fresh || set_done) ? 3'h0 : seen_now;
    next_set_ready = set_fresh | (set_ready & ~set_done);
    next_set_ovw   = (any_acq & set_ready) | (set_ovw & ~set_done);
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      set_ready <= 1'b0;
      set_ovw   <= 1'b0;
      high_seen <= 3'h0;
    end else begin
      set_ready <= next_set_ready;
      set_ovw   <= next_set_ovw;
      high_seen <= next_high_seen;
    end
  end

  logic [7:0] status;

  always_comb begin
    status = aoms_pkg::STATUS_RESET;
    status[aoms_pkg::STAT_XDR]   = ax_x.ready;
    status[aoms_pkg::STAT_YDR]   = ax_y.ready;
    status[aoms_pkg::STAT_ZDR]   = ax_z.ready;
    status[aoms_pkg::STAT_XYZDR] = set_ready;
    status[aoms_pkg::STAT_XOW]   = ax_x.ovw;
    status[aoms_pkg::STAT_YOW]   = ax_y.ovw;
    status[aoms_pkg::STAT_ZOW]   = ax_z.ovw;
    status[aoms_pkg::STAT_XYZOW] = set_ovw;
  end

  // ----------------------------------------------------------------
  // Offset registers and read port
  // ----------------------------------------------------------------
  logic [7:0] off_x;
  logic [7:0] off_y;
  logic [7:0] off_z;
  logic [7:0] next_off_x;
  logic [7:0] next_off_y;
  logic [7:0] next_off_z;
  logic [7:0] next_rdata;
  logic       wr_ok;

  // Writes outside standby are dropped silently; the host sees no error
  always_comb begin
    wr_ok      = reg_wr_in && standby_in;
    next_off_x = (wr_ok && reg_addr_in == aoms_pkg::ACCEL_X_OFFSET_ADDR) ? reg_wdata_in : off_x;
    next_off_y = (wr_ok && reg_addr_in == aoms_pkg::ACCEL_Y_OFFSET_ADDR) ? reg_wdata_in : off_y;
    next_off_z = (wr_ok && reg_addr_in == aoms_pkg::ACCEL_Z_OFFSET_ADDR) ? reg_wdata_in : off_z;
    next_rdata = reg_rdata_out;
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        aoms_pkg::ACCEL_X_OFFSET_ADDR:    next_rdata = off_x;
        aoms_pkg::ACCEL_Y_OFFSET_ADDR:    next_rdata = off_y;
        aoms_pkg::ACCEL_Z_OFFSET_ADDR:    next_rdata = off_z;
        aoms_pkg::MAG_SAMPLE_STATUS_ADDR: next_rdata = status;
        default:                          next_rdata = aoms_pkg::UNMAPPED_READ;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      off_x          <= aoms_pkg::OFFSET_RESET;
      off_y          <= aoms_pkg::OFFSET_RESET;
      off_z          <= aoms_pkg::OFFSET_RESET;
      reg_rdata_out  <= aoms_pkg::UNMAPPED_READ;
      mag_status_out <= aoms_pkg::STATUS_RESET;
    end else begin
      off_x          <= next_off_x;
      off_y          <= next_off_y;
      off_z          <= next_off_z;
      reg_rdata_out  <= next_rdata;
      mag_status_out <= status;
    end
  end

  // ----------------------------------------------------------------
  // Offset correction
  // ----------------------------------------------------------------
  // Saturate rather than wrap so a large offset cannot flip the sign
  function automatic logic [13:0] aoms_correct(input logic [13:0] raw, input logic [7:0] off);
    logic signed [15:0] sum;
    sum = 16'(signed'(raw)) + (16'(signed'(off)) <<< aoms_pkg::OFFSET_SHIFT);
    if (sum > aoms_pkg::ACCEL_MAX) begin
      sum = aoms_pkg::ACCEL_MAX;
    end else if (sum < aoms_pkg::ACCEL_MIN) begin
      sum = aoms_pkg::ACCEL_MIN;
    end
    return sum[13:0];
  endfunction : aoms_correct

  logic        next_accel_valid;
  logic [13:0] next_accel_x;
  logic [13:0] next_accel_y;
  logic [13:0] next_accel_z;

  always_comb begin
    next_accel_valid = accel_valid_in;
    next_accel_x     = accel_valid_in ? aoms_correct(accel_raw_x_in, off_x) : accel_x_out;
    next_accel_y     = accel_valid_in ? aoms_correct(accel_raw_y_in, off_y) : accel_y_out;
    next_accel_z     = accel_valid_in ? aoms_correct(accel_raw_z_in, off_z) : accel_z_out;
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      accel_valid_out <= 1'b0;
      accel_x_out     <= 14'h0000;
      accel_y_out     <= 14'h0000;
      accel_z_out     <= 14'h0000;
    end else begin
      accel_valid_out <= next_accel_valid;
      accel_x_out     <= next_accel_x;
      accel_y_out     <= next_accel_y;
      accel_z_out     <= next_accel_z;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  AST_WRITE_WHILE_ACTIVE: assert property (
    reg_wr_in && !standby_in |=> $stable(off_x) && $stable(off_y) && $stable(off_z))
    else $error("Offset changed while device active");
  AST_X_OFFSET_WRITE: assert property (
    reg_wr_in && standby_in && reg_addr_in == aoms_pkg::ACCEL_X_OFFSET_ADDR
    ##1 reg_rd_in && reg_addr_in == aoms_pkg::ACCEL_X_OFFSET_ADDR |=> reg_rdata_out == $past(reg_wdata_in, 2))
    else $error("X offset readback mismatch");
  AST_Y_OFFSET_WRITE: assert property (
    reg_wr_in && standby_in && reg_addr_in == aoms_pkg::ACCEL_Y_OFFSET_ADDR |=> off_y == $past(reg_wdata_in))
    else $error("Y offset not stored");
  AST_Z_OFFSET_WRITE: assert property (
    reg_wr_in && standby_in && reg_addr_in == aoms_pkg::ACCEL_Z_OFFSET_ADDR |=> off_z == $past(reg_wdata_in))
    else $error("Z offset not stored");
  AST_STATUS_READ: assert property (
    reg_rd_in && reg_addr_in == aoms_pkg::MAG_SAMPLE_STATUS_ADDR |=> reg_rdata_out == mag_status_out)
    else $error("Status read returned wrong byte");
  AST_SET_OVW_SET: assert property (
    any_acq && set_ready |=> set_ovw ##1 mag_status_out[aoms_pkg::STAT_XYZOW])
    else $error("Whole-set overwrite not raised");
  AST_SET_CLEAR: assert property (
    set_done && !any_acq |=> !set_ovw && !set_ready)
    else $error("Whole-set flags not cleared after all high reads");
  AST_Z_OVW: assert property (
    mag_acq_z_in && ax_z.ready |=> ax_z.ovw)
    else $error("Z overwrite not raised");
  AST_Z_OVW_CLR: assert property (
    rd_z_high && !mag_acq_z_in |=> !ax_z.ovw && !ax_z.ready)
    else $error("Z flags not cleared on high read");
  AST_Y_OVW: assert property (
    mag_acq_y_in && ax_y.ready |=> ax_y.ovw)
    else $error("Y overwrite not raised");
  AST_Y_OVW_CLR: assert property (
    rd_y_high && !mag_acq_y_in |=> !ax_y.ovw)
    else $error("Y overwrite not cleared");
  AST_X_OVW: assert property (
    mag_acq_x_in && ax_x.ready |=> ax_x.ovw ##1 mag_status_out[aoms_pkg::STAT_XOW] || rd_x_high)
    else $error("X overwrite not raised");
  AST_X_OVW_CLR: assert property (
    rd_x_high && !mag_acq_x_in |=> !ax_x.ovw)
    else $error("X overwrite not cleared");
  AST_ACCEL_CORRECT: assert property (
    accel_valid_in |=> accel_valid_out && accel_x_out == aoms_correct($past(accel_raw_x_in), $past(off_x)))
    else $error("Corrected acceleration mismatch");
  AST_READY_SET: assert property (
    mag_acq_y_in |=> ax_y.ready ##1 mag_status_out[aoms_pkg::STAT_YDR] || $past(rd_y_high))
    else $error("Y ready not set");
  AST_SET_READY: assert property (
    mag_acq_x_in && mag_acq_y_in && mag_acq_z_in |=> set_ready)
    else $error("Whole-set ready not set");
  AST_READ_STABLE: assert property (
    !reg_wr_in && reg_rd_in && reg_addr_in == aoms_pkg::ACCEL_Z_OFFSET_ADDR |=> reg_rdata_out == off_z)
    else $error("Offset read does not return stored value");
  AST_SET_OVW_HOLD: assert property (
    set_ovw && !set_done |=> set_ovw)
    else $error("Whole-set overwrite dropped before all high reads");
  AST_SET_READY_HOLD: assert property (
    set_ready && !set_done |=> set_ready)
    else $error("Whole-set ready dropped before all high reads");
  AST_X_READY_SET: assert property (
    mag_acq_x_in |=> ax_x.ready)
    else $error("X ready not set");
  AST_Z_READY_SET: assert property (
    mag_acq_z_in |=> ax_z.ready)
    else $error("Z ready not set");
  AST_X_READY_CLR: assert property (
    rd_x_high && !mag_acq_x_in |=> !ax_x.ready)
    else $error("X ready not cleared on high read");
  AST_Y_READY_CLR: assert property (
    rd_y_high && !mag_acq_y_in |=> !ax_y.ready)
    else $error("Y ready not cleared on high read");
  AST_OFFSET_HOLD: assert property (
    !(reg_wr_in && standby_in) |=> $stable(off_x) && $stable(off_y) && $stable(off_z))
    else $error("Offset changed without a standby write");
  AST_ACCEL_CORRECT_YZ: assert property (
    accel_valid_in |=> accel_y_out == aoms_correct($past(accel_raw_y_in), $past(off_y))
                    && accel_z_out == aoms_correct($past(accel_raw_z_in), $past(off_z)))
    else $error("Corrected Y or Z acceleration mismatch");
  AST_ACCEL_HOLD: assert property (
    !accel_valid_in |=> !accel_valid_out && $stable(accel_x_out)
                        && $stable(accel_y_out) && $stable(accel_z_out))
    else $error("Acceleration output moved without a valid sample");
  AST_RDATA_HOLD: assert property (
    !reg_rd_in |=> $stable(reg_rdata_out))
    else $error("Read data changed without a read");

  COV_OVERWRITE: cover property (mag_acq_z_in && ax_z.ready ##1 rd_z_high);
  COV_FULL_SET: cover property (set_ready ##[1:20] set_done);
  COV_BLOCKED_WRITE: cover property (reg_wr_in && !standby_in && reg_addr_in == aoms_pkg::ACCEL_X_OFFSET_ADDR);
  COV_SET_CLEAR_CLASH: cover property (mag_acq_x_in && rd_x_high && ax_x.ready);
  COV_WRITE_THEN_READ: cover property (reg_wr_in && standby_in ##1 reg_rd_in);

endmodule : aoms_regs

/* testbench/aoms_host_model.sv */
`timescale 1ns/100ps
module aoms_host_model (
  input  wire logic       clk_in,       // Core clock
  input  wire logic [7:0] rdata_in,     // Read data from the block
  output logic      [7:0] addr_out,     // Register address
  output logic            wr_out,       // Write strobe
  output logic            rd_out,       // Read strobe
  output logic      [7:0] wdata_out,    // Write data
  output logic            standby_out   // Standby level
);
  initial begin
    addr_out    = 8'h00;
    wr_out      = 1'b0;
    rd_out      = 1'b0;
    wdata_out   = 8'h00;
    standby_out = 1'b0;
  end

  // Offsets are only meant to be written after standby is entered
  task automatic set_standby(input logic s);
    @(negedge clk_in);
    standby_out = s;
  endtask : set_standby

  // Released address and data show the inverse of the last value, never a stale copy
  task automatic xfer(input logic [7:0] addr, input logic wr, input logic [7:0] wdata, output logic [7:0] rdata);
    @(negedge clk_in);
    addr_out  = addr;
    wdata_out = wdata;
    wr_out    = wr;
    rd_out    = !wr;
    @(negedge clk_in);
    rdata     = rdata_in;
    wr_out    = 1'b0;
    rd_out    = 1'b0;
    addr_out  = ~addr;
    wdata_out = ~wdata;
  endtask : xfer

  // Write then read back on the very next edge, the closest spacing the port allows
  task automatic wr_rd(input logic [7:0] addr, input logic [7:0] wdata, output logic [7:0] rdata);
    @(negedge clk_in);
    addr_out  = addr;
    wdata_out = wdata;
    wr_out    = 1'b1;
    @(negedge clk_in);
    wr_out    = 1'b0;
    rd_out    = 1'b1;
    @(negedge clk_in);
    rdata     = rdata_in;
    rd_out    = 1'b0;
    addr_out  = ~addr;
    wdata_out = ~wdata;
  endtask : wr_rd
endmodule : aoms_host_model

/* testbench/testbench.sv */
`timescale 1ns/100ps
module testbench;
  logic             clk_in;
  logic             reset_n_in;
  logic [7:0]       reg_addr;
  logic [7:0]       reg_wdata;
  logic [7:0]       reg_rdata;
  logic [7:0]       mag_status;
  logic             reg_wr;
  logic             reg_rd;
  logic             standby;
  logic [2:0]       acq;
  logic             accel_valid_in;
  logic             accel_valid_out;
  logic [2:0][13:0] raw;
  logic [2:0][13:0] acc;
  logic [7:0]       lfsr;
  logic [7:0]       exp_st;
  logic [2:0]       seen;
  logic [7:0]       off [3];
  logic [7:0]       d;
  int               miscompares;
  int               n_compared;

  aoms_host_model host (.clk_in(clk_in), .rdata_in(reg_rdata), .addr_out(reg_addr), .wr_out(reg_wr),
    .rd_out(reg_rd), .wdata_out(reg_wdata), .standby_out(standby));

  aoms_regs dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .reg_addr_in(reg_addr), .reg_wr_in(reg_wr),
    .reg_rd_in(reg_rd), .reg_wdata_in(reg_wdata), .reg_rdata_out(reg_rdata), .standby_in(standby),
    .mag_acq_x_in(acq[0]), .mag_acq_y_in(acq[1]), .mag_acq_z_in(acq[2]), .accel_valid_in(accel_valid_in),
    .accel_raw_x_in(raw[0]), .accel_raw_y_in(raw[1]), .accel_raw_z_in(raw[2]),
    .accel_valid_out(accel_valid_out), .accel_x_out(acc[0]), .accel_y_out(acc[1]), .accel_z_out(acc[2]),
    .mag_status_out(mag_status));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  function automatic logic [7:0] rnd();
    lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    return lfsr;
  endfunction : rnd

  // Offset step is eight output steps; result clips to the 14-bit range
  function automatic logic [13:0] corr(input logic [13:0] r, input logic [7:0] o);
    int s;
    s = $signed(r) + ($signed(o) * 8);
    if (s > 8191) s = 8191;
    if (s < -8192) s = -8192;
    return s[13:0];
  endfunction : corr

  task automatic wr_off(input int a, input logic [7:0] v, input logic sb);
    host.set_standby(sb);
    host.xfer(aoms_pkg::ACCEL_X_OFFSET_ADDR + 8'(a), 1'b1, v, d);
    if (sb) off[a] = v;
    host.xfer(aoms_pkg::ACCEL_X_OFFSET_ADDR + 8'(a), 1'b0, 8'h00, d);
    check("offset readback", {8'h00, off[a]}, {8'h00, d});
  endtask : wr_off

  task automatic accel(input logic [13:0] rx, input logic [13:0] ry, input logic [13:0] rz);
    @(negedge clk_in);
    accel_valid_in = 1'b1;
    raw = {rz, ry, rx};
    @(negedge clk_in);
    accel_valid_in = 1'b0;
    check("accel valid", 16'h0001, {15'h0000, accel_valid_out});
    for (int a = 0; a < 3; a++) check("accel data", {2'b00, corr(raw[a], off[a])}, {2'b00, acc[a]});
  endtask : accel

  task automatic acq_pulse(input int a);
    @(negedge clk_in);
    acq[a] = 1'b1;
    @(negedge clk_in);
    acq[a] = 1'b0;
    if (exp_st[a]) exp_st[4+a] = 1'b1;
    if (exp_st[3]) exp_st[7] = 1'b1;
    exp_st[a] = 1'b1;
    if (&exp_st[2:0]) begin
      exp_st[3] = 1'b1;
      seen = 3'b000;
    end
    @(negedge clk_in);
    check("status after acquisition", {8'h00, exp_st}, {8'h00, mag_status});
  endtask : acq_pulse

  task automatic rd_high(input int a);
    host.xfer(aoms_pkg::MAG_X_HIGH_ADDR + 8'(2 * a), 1'b0, 8'h00, d);
    exp_st[a] = 1'b0;
    exp_st[4+a] = 1'b0;
    seen[a] = 1'b1;
    if (&seen) begin
      exp_st[7] = 1'b0;
      exp_st[3] = 1'b0;
      seen = 3'b000;
    end
    @(negedge clk_in);
    check("status after high byte read", {8'h00, exp_st}, {8'h00, mag_status});
  endtask : rd_high

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : summarize

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  initial begin
    #100000;
    miscompares++;
    summarize();
  end

  initial begin
    reset_n_in = 1'b0;
    acq = 3'b000;
    accel_valid_in = 1'b0;
    raw = '0;
    exp_st = 8'h00;
    seen = 3'b000;
    off = '{8'h00, 8'h00, 8'h00};
    lfsr = 8'h30;
    miscompares = 0;
    n_compared = 0;
    repeat (16) @(negedge clk_in);
    reset_n_in = 1'b1;
    for (int a = 0; a < 4; a++) begin
      host.xfer(aoms_pkg::ACCEL_X_OFFSET_ADDR + 8'(a), 1'b0, 8'h00, d);
      check("reset value", 16'h0000, {8'h00, d});
    end
    host.set_standby(1'b1);
    host.xfer(aoms_pkg::MAG_SAMPLE_STATUS_ADDR, 1'b1, 8'hFF, d);
    host.xfer(aoms_pkg::MAG_SAMPLE_STATUS_ADDR, 1'b0, 8'h00, d);
    check("status after write", 16'h0000, {8'h00, d});
    for (int a = 0; a < 3; a++) wr_off(a, rnd(), 1'b1);
    for (int a = 0; a < 3; a++) wr_off(a, rnd(), 1'b0);
    for (int i = 0; i < 24; i++) begin
      if (i % 8 == 0) wr_off(i % 3, rnd(), 1'b1);
      accel(14'({rnd(), rnd()} >> 2), 14'({rnd(), rnd()} >> 2), 14'({rnd(), rnd()} >> 2));
    end
    host.set_standby(1'b1);
    host.wr_rd(aoms_pkg::ACCEL_X_OFFSET_ADDR, 8'hE2, d);
    off[0] = 8'hE2;
    check("write then read", 16'h00E2, {8'h00, d});
    for (int a = 0; a < 3; a++) wr_off(a, (a == 1) ? 8'h80 : 8'h7F, 1'b1);
    accel(14'h1FFF, 14'h2000, 14'h1FF0);
    for (int a = 0; a < 3; a++) begin
      acq_pulse(a);
      acq_pulse(a);
      host.xfer(aoms_pkg::MAG_SAMPLE_STATUS_ADDR, 1'b0, 8'h00, d);
      check("status register", {8'h00, exp_st}, {8'h00, d});
      rd_high(a);
    end
    for (int a = 0; a < 3; a++) acq_pulse(a);
    acq_pulse(0);
    rd_high(0);
    rd_high(1);
    rd_high(2);
    summarize();
  end
endmodule : testbench
